/* File: logic/ufc_consts.svh */
/*
 Offsets, field positions, reset values and counts of the serial port
 frame configuration and status block.
 Assumes a 32-bit AXI4-Lite bus where register index N sits at byte 4*N.
*/
// How it works
// - Auto mode drops request-to-send when one slot left
// - Handshake enable switches request/clear-to-send on, off
// - Handshake off: clear-to-send treated as asserted
// - Bit 4: even parity zero, odd one
// - Bit 3: parity bit omitted or added
// - Bit 2: one or two stop bits
// - Bit 1: seven or eight data bits
// - Manual request-to-send bit drives pin, inverted
// - Bad parity on FIFO entry sets flag
// - Missing stop bit on FIFO entry sets flag
// - Data register read clears three error flags
// - Character lost to full receive FIFO: overrun
// - Transmit-space flag while transmit FIFO not full
// - Clear-to-send flag is inverse of pin, low means go
// - Data write pushes transmit, read pops receive
// - Works as serial port only in mode one
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH

// Register indexes; byte address is four times the index
`define UFC_IDX_DATA 16'h449E
`define UFC_IDX_STATUS 16'h44A4
`define UFC_IDX_MODE 16'h44AA
`define UFC_IDX_CFG 16'h44AE
`define UFC_IDX_IRQ_STAT 16'h44C0
`define UFC_IDX_IRQ_MASK 16'h44C2

// Frame configuration fields
`define UFC_CFG_AUTO 6
`define UFC_CFG_HS 5
`define UFC_CFG_ODD 4
`define UFC_CFG_PAR 3
`define UFC_CFG_TWO_STOP 2
`define UFC_CFG_EIGHT 1
`define UFC_CFG_RTS 0
`define UFC_CFG_RESET 7'h00

// Status fields
`define UFC_ST_TX_IDLE 6
`define UFC_ST_PAR_ERR 5
`define UFC_ST_FRM_ERR 4
`define UFC_ST_OVR 3
`define UFC_ST_TX_SPACE 2
`define UFC_ST_RX_VALID 1
`define UFC_ST_CTS 0

// Controller mode
`define UFC_MODE_OFF 2'h0
`define UFC_MODE_UART 2'h1

// Interrupt status bits: rx char, tx drained, overrun, parity, framing
`define UFC_IRQ_RX 0
`define UFC_IRQ_TX_EMPTY 1
`define UFC_IRQ_OVR 2
`define UFC_IRQ_PAR 3
`define UFC_IRQ_FRM 4
`define UFC_IRQ_W 5

`define UFC_RESP_OKAY 2'h0
`define UFC_RESP_DECERR 2'h3

`endif

/* File: logic/ufc_pkg.sv */
/*
 Types shared by the serial port frame configuration block.
 Assumes ufc_consts.svh is available on the include path.
*/
`default_nettype none
package ufc_pkg;

   // Frame shape handed to the serializer and deserializer
   typedef struct packed {
      logic eight_bit_select;
      logic two_stop_select;
      logic parity_enable;
      logic odd_parity_select;
   } ufc_frame_type;

   // Character handed over by the deserializer
   typedef struct packed {
      logic [7:0] data;
      logic parity_bit;
      logic stop_ok;
   } ufc_rx_char_type;

endpackage
`default_nettype wire

/* File: logic/ufc_top.sv */
/*
 Frame configuration, flow control, status flags, data FIFOs and
 AXI4-Lite register slave of the asynchronous serial port.
 Assumes a serializer and deserializer on the same clock, and a
 clear-to-send pin arriving asynchronously.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_consts.svh"
module ufc_top
   import ufc_pkg::*;
#(
   parameter int ADDR_W = 20,
   parameter int TX_DEPTH = 4,
   parameter int RX_DEPTH = 4
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic [7:0] TX_DATA_O,
   output logic TX_VALID_O,
   input wire logic TX_READY_I,
   input wire logic TX_BUSY_I,
   input wire ufc_rx_char_type RX_CHAR_I,
   input wire logic RX_STROBE_I,
   output ufc_frame_type FRAME_O,
   input wire logic CLEAR_TO_SEND_N_I,
   output logic REQUEST_TO_SEND_N_O,
   output logic IRQ_O
);

   localparam int TAW = $clog2(TX_DEPTH);
   localparam int RAW = $clog2(RX_DEPTH);
   localparam int IW = ADDR_W - 2;
   localparam logic [TAW:0] TX_FULL = (TAW+1)'(TX_DEPTH);
   localparam logic [RAW:0] RX_FULL = (RAW+1)'(RX_DEPTH);
   localparam logic [RAW:0] RX_ONE_LEFT = (RAW+1)'(RX_DEPTH - 1);

   typedef struct packed {
      logic [6:0] cfg;
      logic [1:0] mode;
      logic [`UFC_IRQ_W-1:0] irq_st;
      logic [`UFC_IRQ_W-1:0] irq_mask;
      logic par_err;
      logic frm_err;
      logic ovr;
      logic [TX_DEPTH-1:0][7:0] txm;
      logic [TAW-1:0] tx_wr;
      logic [TAW-1:0] tx_rd;
      logic [TAW:0] tx_cnt;
      logic [RX_DEPTH-1:0][7:0] rxm;
      logic [RAW-1:0] rx_wr;
      logic [RAW-1:0] rx_rd;
      logic [RAW:0] rx_cnt;
      logic cts_meta;
      logic cts_sync;
      logic rts_n;
      logic txv;
      logic [7:0] txd;
      logic irq;
      logic awr;
      logic wr;
      logic aw_got;
      logic w_got;
      logic [IW-1:0] wa;
      logic [15:0] wd;
      logic [1:0] ws;
      logic bv;
      logic [1:0] br;
      logic arr;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } ufc_state_type;

   ufc_state_type s_ff;
   ufc_state_type nxt_s;

   logic uart;
   logic cts_ok;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic rx_par_bad;
   logic ar_take;
   logic [IW-1:0] ra;
   logic [15:0] status;
   logic [15:0] wmask;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s = s_ff;
      uart = (s_ff.mode == `UFC_MODE_UART);
      // Synchroniser: second stage alone feeds the logic
      nxt_s.cts_meta = CLEAR_TO_SEND_N_I;
      nxt_s.cts_sync = s_ff.cts_meta;
      cts_ok = !s_ff.cfg[`UFC_CFG_HS] || !s_ff.cts_sync;
      status = 16'h0000;
      status[`UFC_ST_TX_IDLE] = (s_ff.tx_cnt == '0) && !TX_BUSY_I;
      status[`UFC_ST_PAR_ERR] = s_ff.par_err;
      status[`UFC_ST_FRM_ERR] = s_ff.frm_err;
      status[`UFC_ST_OVR] = s_ff.ovr;
      status[`UFC_ST_TX_SPACE] = (s_ff.tx_cnt < TX_FULL);
      status[`UFC_ST_RX_VALID] = (s_ff.rx_cnt != '0);
      status[`UFC_ST_CTS] = !s_ff.cts_sync;
      wmask = {{8{s_ff.ws[1]}}, {8{s_ff.ws[0]}}};

      // Write channel: address and data taken in either order
      tx_push = 1'b0;
      nxt_s.awr = S_AXI_AWVALID_I && !s_ff.awr && !s_ff.aw_got && !s_ff.bv;
      nxt_s.wr = S_AXI_WVALID_I && !s_ff.wr && !s_ff.w_got && !s_ff.bv;
      if (s_ff.awr && S_AXI_AWVALID_I) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.wa = S_AXI_AWADDR_I[ADDR_W-1:2];
      end
      if (s_ff.wr && S_AXI_WVALID_I) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wd = S_AXI_WDATA_I[15:0];
         nxt_s.ws = S_AXI_WSTRB_I[1:0];
      end
      if (s_ff.aw_got && s_ff.w_got && !s_ff.bv) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bv = 1'b1;
         nxt_s.br = `UFC_RESP_OKAY;
         case (s_ff.wa)
            IW'(`UFC_IDX_DATA): begin
               // A byte written while full or disabled is dropped
               tx_push = s_ff.ws[0] && uart && (s_ff.tx_cnt < TX_FULL);
            end
            IW'(`UFC_IDX_MODE): begin
               if (s_ff.ws[0]) begin
                  nxt_s.mode = s_ff.wd[1:0];
               end
            end
            IW'(`UFC_IDX_CFG): begin
               if (s_ff.ws[0]) begin
                  nxt_s.cfg = s_ff.wd[6:0];
               end
            end
            IW'(`UFC_IDX_IRQ_STAT): begin
               nxt_s.irq_st = s_ff.irq_st & ~(s_ff.wd[`UFC_IRQ_W-1:0] &
                                              wmask[`UFC_IRQ_W-1:0]);
            end
            IW'(`UFC_IDX_IRQ_MASK): begin
               if (s_ff.ws[0]) begin
                  nxt_s.irq_mask = s_ff.wd[`UFC_IRQ_W-1:0];
               end
            end
            IW'(`UFC_IDX_STATUS): begin
            end
            default: begin
               nxt_s.br = `UFC_RESP_DECERR;
            end
         endcase
      end
      if (s_ff.bv && S_AXI_BREADY_I) begin
         nxt_s.bv = 1'b0;
      end

      // Read channel: a data read pops and clears the error flags
      rx_pop = 1'b0;
      ar_take = s_ff.arr && S_AXI_ARVALID_I;
      ra = S_AXI_ARADDR_I[ADDR_W-1:2];
      nxt_s.arr = S_AXI_ARVALID_I && !s_ff.arr && !s_ff.rv;
      if (ar_take) begin
         nxt_s.rv = 1'b1;
         nxt_s.rr = `UFC_RESP_OKAY;
         nxt_s.rd = 32'h0000_0000;
         case (ra)
            IW'(`UFC_IDX_DATA): begin
               nxt_s.rd[7:0] = s_ff.rxm[s_ff.rx_rd];
               rx_pop = (s_ff.rx_cnt != '0);
               nxt_s.par_err = 1'b0;
               nxt_s.frm_err = 1'b0;
               nxt_s.ovr = 1'b0;
            end
            IW'(`UFC_IDX_STATUS): nxt_s.rd[15:0] = status;
            IW'(`UFC_IDX_MODE): nxt_s.rd[1:0] = s_ff.mode;
            IW'(`UFC_IDX_CFG): nxt_s.rd[6:0] = s_ff.cfg;
            IW'(`UFC_IDX_IRQ_STAT): nxt_s.rd[`UFC_IRQ_W-1:0] = s_ff.irq_st;
            IW'(`UFC_IDX_IRQ_MASK): nxt_s.rd[`UFC_IRQ_W-1:0] = s_ff.irq_mask;
            default: nxt_s.rr = `UFC_RESP_DECERR;
         endcase
      end
      if (s_ff.rv && S_AXI_RREADY_I) begin
         nxt_s.rv = 1'b0;
      end

      // Transmit FIFO; a taken character always finishes in the shifter
      tx_pop = s_ff.txv && TX_READY_I;
      if (tx_push) begin
         nxt_s.txm[s_ff.tx_wr] = s_ff.wd[7:0];
         nxt_s.tx_wr = s_ff.tx_wr + TAW'(1);
      end
      if (tx_pop) begin
         nxt_s.tx_rd = s_ff.tx_rd + TAW'(1);
         if (s_ff.tx_cnt == (TAW+1)'(1) && !tx_push) begin
            nxt_s.irq_st[`UFC_IRQ_TX_EMPTY] = 1'b1;
         end
      end
      nxt_s.tx_cnt = s_ff.tx_cnt + (TAW+1)'(tx_push) - (TAW+1)'(tx_pop);
      // Held characters stay queued while clear-to-send is off
      nxt_s.txv = (nxt_s.tx_cnt != '0) && cts_ok && uart;
      nxt_s.txd = nxt_s.txm[nxt_s.tx_rd];

      // Receive FIFO with error checks at entry
      rx_par_bad = s_ff.cfg[`UFC_CFG_PAR] &&
                   ((^{s_ff.cfg[`UFC_CFG_EIGHT] & RX_CHAR_I.data[7],
                       RX_CHAR_I.data[6:0], RX_CHAR_I.parity_bit})
                    != s_ff.cfg[`UFC_CFG_ODD]);
      rx_push = 1'b0;
      if (RX_STROBE_I && uart) begin
         if (s_ff.rx_cnt == RX_FULL && !rx_pop) begin
            nxt_s.ovr = 1'b1;
            nxt_s.irq_st[`UFC_IRQ_OVR] = 1'b1;
         end else begin
            rx_push = 1'b1;
            nxt_s.irq_st[`UFC_IRQ_RX] = 1'b1;
            if (rx_par_bad) begin
               nxt_s.par_err = 1'b1;
               nxt_s.irq_st[`UFC_IRQ_PAR] = 1'b1;
            end
            if (!RX_CHAR_I.stop_ok) begin
               nxt_s.frm_err = 1'b1;
               nxt_s.irq_st[`UFC_IRQ_FRM] = 1'b1;
            end
         end
      end
      if (rx_push) begin
         nxt_s.rxm[s_ff.rx_wr] = s_ff.cfg[`UFC_CFG_EIGHT] ? RX_CHAR_I.data :
                                 {1'b0, RX_CHAR_I.data[6:0]};
         nxt_s.rx_wr = s_ff.rx_wr + RAW'(1);
      end
      if (rx_pop) begin
         nxt_s.rx_rd = s_ff.rx_rd + RAW'(1);
      end
      nxt_s.rx_cnt = s_ff.rx_cnt + (RAW+1)'(rx_push) - (RAW+1)'(rx_pop);

      // Request-to-send: low asserts, so the peer may send
      if (!uart || !nxt_s.cfg[`UFC_CFG_HS]) begin
         nxt_s.rts_n = 1'b1;
      end else if (nxt_s.cfg[`UFC_CFG_AUTO]) begin
         nxt_s.rts_n = (nxt_s.rx_cnt >= RX_ONE_LEFT);
      end else begin
         nxt_s.rts_n = !nxt_s.cfg[`UFC_CFG_RTS];
      end
      nxt_s.irq = |(nxt_s.irq_st & nxt_s.irq_mask);
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_ff <= '0;
         s_ff.cfg <= `UFC_CFG_RESET;
         s_ff.mode <= `UFC_MODE_OFF;
         s_ff.rts_n <= 1'b1;
         s_ff.cts_meta <= 1'b1;
         s_ff.cts_sync <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign S_AXI_AWREADY_O = s_ff.awr;
   assign S_AXI_WREADY_O = s_ff.wr;
   assign S_AXI_BVALID_O = s_ff.bv;
   assign S_AXI_BRESP_O = s_ff.br;
   assign S_AXI_ARREADY_O = s_ff.arr;
   assign S_AXI_RVALID_O = s_ff.rv;
   assign S_AXI_RDATA_O = s_ff.rd;
   assign S_AXI_RRESP_O = s_ff.rr;
   assign TX_DATA_O = s_ff.txd;
   assign TX_VALID_O = s_ff.txv;
   assign FRAME_O = '{eight_bit_select: s_ff.cfg[`UFC_CFG_EIGHT],
                      two_stop_select: s_ff.cfg[`UFC_CFG_TWO_STOP],
                      parity_enable: s_ff.cfg[`UFC_CFG_PAR],
                      odd_parity_select: s_ff.cfg[`UFC_CFG_ODD]};
   assign REQUEST_TO_SEND_N_O = s_ff.rts_n;
   assign IRQ_O = s_ff.irq;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   a_rts_auto_level: assert property (
      (uart && s_ff.cfg[`UFC_CFG_HS] && s_ff.cfg[`UFC_CFG_AUTO])
      |-> (REQUEST_TO_SEND_N_O == (s_ff.rx_cnt >= RX_ONE_LEFT)))
      else $error("auto request-to-send does not follow receive fill");
   a_rts_off_high: assert property (
      !(uart && s_ff.cfg[`UFC_CFG_HS]) |-> REQUEST_TO_SEND_N_O)
      else $error("request-to-send asserted with handshake off");
   a_rts_manual_pin: assert property (
      (uart && s_ff.cfg[`UFC_CFG_HS] && !s_ff.cfg[`UFC_CFG_AUTO])
      |-> (REQUEST_TO_SEND_N_O == !s_ff.cfg[`UFC_CFG_RTS]))
      else $error("manual request-to-send not on pin");
   a_cts_holds_tx: assert property (
      (s_ff.cfg[`UFC_CFG_HS] && s_ff.cts_sync) |=> !TX_VALID_O)
      else $error("transmit offered while clear-to-send off");
   a_cts_ignored_off: assert property (
      (uart && !s_ff.cfg[`UFC_CFG_HS] && s_ff.tx_cnt != '0 && !tx_pop)
      |=> TX_VALID_O)
      else $error("transmit held with handshake off");
   a_par_err_set: assert property (
      (RX_STROBE_I && uart && rx_push && rx_par_bad) |=> s_ff.par_err)
      else $error("parity error not flagged");
   a_frm_err_set: assert property (
      (rx_push && !RX_CHAR_I.stop_ok) |=> s_ff.frm_err)
      else $error("framing error not flagged");
   a_ovr_set: assert property (
      (RX_STROBE_I && uart && s_ff.rx_cnt == RX_FULL && !rx_pop)
      |=> s_ff.ovr && s_ff.rx_cnt == RX_FULL)
      else $error("overrun not flagged or character kept");
   a_read_clears: assert property (
      (ar_take && ra == IW'(`UFC_IDX_DATA) && !RX_STROBE_I)
      |=> !s_ff.par_err && !s_ff.frm_err && !s_ff.ovr)
      else $error("data read left error flags set");
   a_space_read: assert property (
      (ar_take && ra == IW'(`UFC_IDX_STATUS))
      |=> S_AXI_RDATA_O[`UFC_ST_TX_SPACE] == ($past(s_ff.tx_cnt) < TX_FULL))
      else $error("transmit-space flag wrong");
   a_mode_gate: assert property (
      (s_ff.mode != `UFC_MODE_UART) |=> !TX_VALID_O)
      else $error("transmit active outside serial mode");
   a_irq_level: assert property (
      IRQ_O == |(s_ff.irq_st & s_ff.irq_mask))
      else $error("interrupt output does not match status and mask");

endmodule // ufc_top
`default_nettype wire

/* File: verif/ufc_peer.sv */
/*
 Remote serial peer: a serializer sink for transmit bytes and a
 deserializer source of received characters, plus the peer's CTS pin.
 Assumes the bench steers stall and cts_hold by name and calls send_char.
*/
`timescale 1ns/1ps
`default_nettype none
module ufc_peer
   import ufc_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o = 1'b0,
   output logic tx_busy_o = 1'b0,
   output ufc_rx_char_type rx_char_o = '0,
   output logic rx_strobe_o = 1'b0,
   output logic cts_n_o
);
   logic stall = 1'b1;
   logic cts_hold = 1'b1;
   logic [7:0] got[$];
   int busy = 0;

   assign cts_n_o = cts_hold;

   ////////////////////////////////////////////////////////////////////////////////
   // Shifting takes a few cycles, so busy follows every byte taken
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         got.push_back(tx_data_i);
         busy <= 3;
         tx_busy_o <= 1'b1;
         tx_ready_o <= 1'b0;
      end else begin
         if (busy > 0) busy <= busy - 1;
         tx_busy_o <= busy > 1;
         tx_ready_o <= !stall && busy <= 1;
      end
   end

   // Outside the strobe the character lines carry no stale copy
   task automatic send_char(input ufc_rx_char_type c);
      @(posedge clk_i);
      rx_char_o <= c;
      rx_strobe_o <= 1'b1;
      @(posedge clk_i);
      rx_char_o <= ~c;
      rx_strobe_o <= 1'b0;
   endtask
endmodule // ufc_peer
`default_nettype wire

/* File: verif/testbench.sv */
/*
 Self-checking bench of the serial port configuration and status block.
 Assumes ufc_pkg, ufc_top and ufc_peer are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ufc_consts.svh"
module testbench
   import ufc_pkg::*;
;
   localparam int DEPTH = 4;
   logic clk = 1'b0, rst = 1'b1;
   logic [19:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata, rdv;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, tx_busy;
   logic rx_strobe, cts_n, rts_n, irq, par = 1'b0, frm = 1'b0, ovr = 1'b0;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] tx_data, b;
   logic [7:0] rcfg[3] = '{8'h21, 8'h20, 8'h01};
   logic [7:0] txq[$], rxq[$];
   ufc_rx_char_type rx_char, c;
   ufc_frame_type frame;
   int n_fail = 0, tests_run = 0, n;
   int unsigned seed = 37264;

   always #5 clk = ~clk;

   ufc_top #(.ADDR_W(20), .TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH)) uut (.CLK_I(clk), .RST_I(rst),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TX_DATA_O(tx_data),
      .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .TX_BUSY_I(tx_busy), .RX_CHAR_I(rx_char),
      .RX_STROBE_I(rx_strobe), .FRAME_O(frame), .CLEAR_TO_SEND_N_I(cts_n),
      .REQUEST_TO_SEND_N_O(rts_n), .IRQ_O(irq));

   ufc_peer u_peer (.clk_i(clk), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .tx_busy_o(tx_busy), .rx_char_o(rx_char),
      .rx_strobe_o(rx_strobe), .cts_n_o(cts_n));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] st_exp(input logic idle, input logic cts);
      return 32'({idle, par, frm, ovr, txq.size() < DEPTH, rxq.size() > 0, cts});
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic guard(inout int k);
      @(posedge clk);
      k++;
      if (k > 400) begin
         chk("wait bound", 32'(k), 32'd0);
         tally_and_finish();
      end
   endtask

   // Bus master: hold each channel until its own ready, answers taken at the edge
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      awaddr <= 20'({idx, 2'b00});
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         guard(k);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] idx);
      int k;
      k = 0;
      @(posedge clk);
      araddr <= 20'({idx, 2'b00});
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         guard(k);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rdv = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      u_peer.send_char(ufc_rx_char_type'(10'h155));
      rd(`UFC_IDX_STATUS);
      chk("status after reset", rdv, st_exp(1'b1, 1'b0));
      chk("rts after reset", 32'(rts_n), 32'd1);
      for (int i = 0; i < 16; i++) begin
         b = 8'(i << 1);
         wr(`UFC_IDX_CFG, 32'(b));
         rd(`UFC_IDX_CFG);
         chk("config", rdv, 32'(b));
         chk("frame shape", 32'(frame), 32'({b[1], b[2], b[3], b[4]}));
      end
      wr(`UFC_IDX_MODE, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(`UFC_IDX_CFG, 32'(rcfg[i]));
         repeat (2) @(posedge clk);
         chk("manual rts", 32'(rts_n), 32'(i != 0));
      end
      // Transmit with handshake off: the high CTS pin must not hold bytes back
      wr(`UFC_IDX_CFG, 32'h0);
      for (int i = 0; i <= DEPTH; i++) begin
         b = 8'(xs());
         if (txq.size() < DEPTH) txq.push_back(b);
         wr(`UFC_IDX_DATA, 32'(b));
      end
      rd(`UFC_IDX_STATUS);
      chk("status tx full", rdv, st_exp(1'b0, 1'b0));
      u_peer.stall <= 1'b0;
      n = 0;
      while (u_peer.got.size() < DEPTH) guard(n);
      foreach (txq[i]) chk("tx byte", 32'(u_peer.got[i]), 32'(txq[i]));
      repeat (6) @(posedge clk);
      txq.delete();
      u_peer.got.delete();
      rd(`UFC_IDX_STATUS);
      chk("status tx drained", rdv, st_exp(1'b1, 1'b0));
      wr(`UFC_IDX_CFG, 32'h20);
      b = 8'(xs());
      txq.push_back(b);
      wr(`UFC_IDX_DATA, 32'(b));
      repeat (8) @(posedge clk);
      chk("tx held by cts", 32'(u_peer.got.size()), 32'd0);
      rd(`UFC_IDX_STATUS);
      chk("status cts off", rdv, st_exp(1'b0, 1'b0));
      u_peer.cts_hold <= 1'b0;
      n = 0;
      while (u_peer.got.size() < 1) guard(n);
      chk("tx byte after cts", 32'(u_peer.got[0]), 32'(b));
      txq.delete();
      repeat (6) @(posedge clk);
      // Receive: auto flow control, even parity, eight bits, one bad stop
      wr(`UFC_IDX_CFG, 32'h6A);
      for (int i = 0; i <= DEPTH; i++) begin
         c = ufc_rx_char_type'(10'(xs()));
         c.stop_ok = i != 1;
         c.parity_bit = (i == 0) ? ~^c.data : ^c.data;
         u_peer.send_char(c);
         if (rxq.size() < DEPTH) begin
            rxq.push_back(c.data);
            par |= ^{c.data, c.parity_bit};
            frm |= !c.stop_ok;
         end else begin
            ovr = 1'b1;
         end
         repeat (2) @(posedge clk);
         chk("auto rts", 32'(rts_n), 32'(rxq.size() >= DEPTH - 1));
      end
      rd(`UFC_IDX_STATUS);
      chk("status rx errors", rdv, st_exp(1'b1, 1'b1));
      chk("irq masked", 32'(irq), 32'd0);
      wr(`UFC_IDX_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq raised", 32'(irq), 32'd1);
      rd(`UFC_IDX_IRQ_STAT);
      chk("irq status", rdv, 32'h1F);
      wr(`UFC_IDX_IRQ_STAT, 32'h1F);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'(irq), 32'd0);
      while (rxq.size() > 0) begin
         rd(`UFC_IDX_DATA);
         chk("rx byte", rdv, 32'(rxq.pop_front()));
         {par, frm, ovr} = 3'h0;
         rd(`UFC_IDX_STATUS);
         chk("status after pop", rdv, st_exp(1'b1, 1'b1));
         chk("auto rts", 32'(rts_n), 32'(rxq.size() >= DEPTH - 1));
      end
      wr(16'h4400, 32'h0);
      chk("unmapped write", 32'(resp), 32'(`UFC_RESP_DECERR));
      rd(16'h4400);
      chk("unmapped read", {rdv[29:0], resp}, 32'(`UFC_RESP_DECERR));
      wr(`UFC_IDX_STATUS, 32'h7F);
      chk("status write resp", 32'(resp), 32'(`UFC_RESP_OKAY));
      // Seven bits, parity off: bit 7 is stripped and no parity error may show
      wr(`UFC_IDX_CFG, 32'h0);
      u_peer.send_char('{data: 8'hFF, parity_bit: 1'b1, stop_ok: 1'b1});
      rxq.push_back(8'h7F);
      rd(`UFC_IDX_STATUS);
      chk("status seven bit", rdv, st_exp(1'b1, 1'b1));
      rd(`UFC_IDX_DATA);
      chk("seven bit byte", rdv, 32'(rxq.pop_front()));
      // Odd parity over seven bits: bit 7 stays out of the sum
      wr(`UFC_IDX_CFG, 32'h18);
      for (int i = 0; i < 2; i++) begin
         u_peer.send_char('{data: 8'hFE, parity_bit: 1'(i == 0), stop_ok: 1'b1});
         rxq.push_back(8'h7E);
         par = 1'(i);
         rd(`UFC_IDX_STATUS);
         chk("status odd parity", rdv, st_exp(1'b1, 1'b1));
         rd(`UFC_IDX_DATA);
         chk("odd parity byte", rdv, 32'(rxq.pop_front()));
         par = 1'b0;
      end
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
